// file: src/irq_enable_pkg.sv
// Constants and types for the interrupt enable masking block
// Summary of operation
// - Enable bit 7 gates almost-full flag
// - Enable bit 5 gates data-ready flag
// - Enable bit 4 gates frequency-loss flag
// - Enable bit 3 gates frequency-acquired flag
// - Enable bits 2,1 gate phase flags
// - Second enable bit 7 gates lead-on
// - Second bits 6,5 gate range flags
// - Second bit 4 gates drive-range flag
// - Second bits 3..0 gate lead-off flags
package irq_enable_pkg;

  // Register offsets
  localparam logic [7:0] OFFSET_ENABLE_FIRST  = 8'h80;
  localparam logic [7:0] OFFSET_ENABLE_SECOND = 8'h81;
  localparam logic [7:0] OFFSET_PENDING_FIRST  = 8'h82;
  localparam logic [7:0] OFFSET_PENDING_SECOND = 8'h83;
  localparam logic [7:0] OFFSET_IDENTIFIER    = 8'hff;

  // Reset values and writable bits
  localparam logic [7:0] RESET_ENABLE_FIRST  = 8'h00;
  localparam logic [7:0] RESET_ENABLE_SECOND = 8'h00;
  localparam logic [7:0] WMASK_ENABLE_FIRST  = 8'hbe;
  localparam logic [7:0] WMASK_ENABLE_SECOND = 8'hff;
  localparam logic [7:0] READ_UNMAPPED       = 8'h00;

  // Arbitrary identifier value, not tied to any real part
  localparam logic [7:0] IDENTIFIER_DEFAULT = 8'h5a;

  // Field positions, first enable register and first status register
  localparam int ALMOST_FULL_IRQ_ENABLE_BIT    = 7;
  localparam int DATA_READY_IRQ_ENABLE_BIT     = 5;
  localparam int FREQ_LOSS_IRQ_ENABLE_BIT      = 4;
  localparam int FREQ_ACQUIRED_IRQ_ENABLE_BIT  = 3;
  localparam int PHASE_LOSS_IRQ_ENABLE_BIT     = 2;
  localparam int PHASE_ACQUIRED_IRQ_ENABLE_BIT = 1;

  // Field positions, second enable register and second status register
  localparam int LEAD_ON_IRQ_ENABLE_BIT           = 7;
  localparam int OVERRANGE_IRQ_ENABLE_BIT         = 6;
  localparam int UNDERRANGE_IRQ_ENABLE_BIT        = 5;
  localparam int DRIVE_RANGE_IRQ_ENABLE_BIT       = 4;
  localparam int POS_HIGH_LEADOFF_IRQ_ENABLE_BIT  = 3;
  localparam int POS_LOW_LEADOFF_IRQ_ENABLE_BIT   = 2;
  localparam int NEG_HIGH_LEADOFF_IRQ_ENABLE_BIT  = 1;
  localparam int NEG_LOW_LEADOFF_IRQ_ENABLE_BIT   = 0;

  typedef struct packed {
    logic almost_full_flag;
    logic spare_hi;
    logic data_ready_flag;
    logic freq_loss_flag;
    logic freq_acquired_flag;
    logic phase_loss_flag;
    logic phase_acquired_flag;
    logic spare_lo;
  } status_first_t;

  typedef struct packed {
    logic lead_on_flag;
    logic overrange_flag;
    logic underrange_flag;
    logic drive_range_flag;
    logic pos_high_leadoff_flag;
    logic pos_low_leadoff_flag;
    logic neg_high_leadoff_flag;
    logic neg_low_leadoff_flag;
  } status_second_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// file: src/flag_mask_merge.sv
// Gating of status flags by enable bits into two pending vectors and one summary bit
`timescale 1ns/100ps
module flag_mask_merge (
  input  wire logic [7:0] flags_first,
  input  wire logic [7:0] flags_second,
  input  wire logic [7:0] enable_first,
  input  wire logic [7:0] enable_second,
  output logic      [7:0] pending_first,
  output logic      [7:0] pending_second,
  output logic            pending_any
);

  // Reserved flag positions are masked by the enable register itself
  assign pending_first  = flags_first & enable_first;
  assign pending_second = flags_second & enable_second;
  assign pending_any    = (|pending_first) | (|pending_second);

endmodule

// file: src/irq_enable_mask.sv
// Interrupt enable registers, identifier register and interrupt output
`timescale 1ns/100ps
module irq_enable_mask
  import irq_enable_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = irq_enable_pkg::IDENTIFIER_DEFAULT
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire irq_enable_pkg::reg_req_t       bus_req,
  input  wire irq_enable_pkg::status_first_t  status_first,
  input  wire irq_enable_pkg::status_second_t status_second,
  output logic [7:0]                          rd_data_q,
  output logic                                irq_q
);
  import irq_enable_pkg::*;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  logic [7:0] en_first_q;
  logic [7:0] en_first_d;
  logic [7:0] en_second_q;
  logic [7:0] en_second_d;
  logic [7:0] rd_data_d;
  logic [7:0] pend_first;
  logic [7:0] pend_second;
  logic       pend_any;

  wire wr_first  = bus_req.wr && addr_is(bus_req.addr, OFFSET_ENABLE_FIRST);
  wire wr_second = bus_req.wr && addr_is(bus_req.addr, OFFSET_ENABLE_SECOND);

  // Reserved positions never store, so they read back as zero
  assign en_first_d  = wr_first  ? (bus_req.wdata & WMASK_ENABLE_FIRST)  : en_first_q;
  assign en_second_d = wr_second ? (bus_req.wdata & WMASK_ENABLE_SECOND) : en_second_q;

  flag_mask_merge u_merge (
    .flags_first    (status_first),
    .flags_second   (status_second),
    .enable_first   (en_first_q),
    .enable_second  (en_second_q),
    .pending_first  (pend_first),
    .pending_second (pend_second),
    .pending_any    (pend_any)
  );

  // Read decode; the identifier has no write path at all
  wire [7:0] rd_sel =
    addr_is(bus_req.addr, OFFSET_ENABLE_FIRST)   ? en_first_q  :
    addr_is(bus_req.addr, OFFSET_ENABLE_SECOND)  ? en_second_q :
    addr_is(bus_req.addr, OFFSET_PENDING_FIRST)  ? pend_first  :
    addr_is(bus_req.addr, OFFSET_PENDING_SECOND) ? pend_second :
    addr_is(bus_req.addr, OFFSET_IDENTIFIER)     ? DEVICE_ID   : READ_UNMAPPED;

  // Data stand only in the cycle after the strobe, zero otherwise
  assign rd_data_d = bus_req.rd ? rd_sel : READ_UNMAPPED;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_first_q  <= RESET_ENABLE_FIRST;
      en_second_q <= RESET_ENABLE_SECOND;
      rd_data_q   <= READ_UNMAPPED;
      irq_q       <= 1'b0;
    end else begin
      en_first_q  <= en_first_d;
      en_second_q <= en_second_d;
      rd_data_q   <= rd_data_d;
      // Registered so the pin never glitches while flags settle
      irq_q       <= pend_any;
    end
  end

  a_full_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    status_first.almost_full_flag && en_first_q[ALMOST_FULL_IRQ_ENABLE_BIT] |=> irq_q)
    else $error("almost-full flag enabled but no interrupt");

  a_ready_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    status_first.data_ready_flag && en_first_q[DATA_READY_IRQ_ENABLE_BIT] |=> irq_q)
    else $error("data-ready flag enabled but no interrupt");

  a_freq_loss_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    status_first.freq_loss_flag && en_first_q[FREQ_LOSS_IRQ_ENABLE_BIT] |=> irq_q)
    else $error("frequency-loss flag enabled but no interrupt");

  a_freq_acq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    status_first.freq_acquired_flag && en_first_q[FREQ_ACQUIRED_IRQ_ENABLE_BIT] |=> irq_q)
    else $error("frequency-acquired flag enabled but no interrupt");

  a_phase_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (status_first.phase_loss_flag && en_first_q[PHASE_LOSS_IRQ_ENABLE_BIT]) ||
    (status_first.phase_acquired_flag && en_first_q[PHASE_ACQUIRED_IRQ_ENABLE_BIT])
    |=> irq_q)
    else $error("phase flag enabled but no interrupt");

  a_lead_on_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    status_second.lead_on_flag && en_second_q[LEAD_ON_IRQ_ENABLE_BIT] |=> irq_q)
    else $error("lead-on flag enabled but no interrupt");

  a_range_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (status_second.overrange_flag && en_second_q[OVERRANGE_IRQ_ENABLE_BIT]) ||
    (status_second.underrange_flag && en_second_q[UNDERRANGE_IRQ_ENABLE_BIT])
    |=> irq_q)
    else $error("range flag enabled but no interrupt");

  a_drive_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    status_second.drive_range_flag && en_second_q[DRIVE_RANGE_IRQ_ENABLE_BIT] |=> irq_q)
    else $error("drive-range flag enabled but no interrupt");

  a_leadoff_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (|(status_second[3:0] & en_second_q[3:0])) |=> irq_q)
    else $error("lead-off flag enabled but no interrupt");

  a_irq_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 irq_q |-> $past(|(status_first & en_first_q)) || $past(|(status_second & en_second_q)))
    else $error("interrupt raised without an enabled set flag");

  a_reset_quiet: assert property (@(posedge core_clk)
    !rst_n |=> en_first_q == RESET_ENABLE_FIRST && en_second_q == RESET_ENABLE_SECOND
    && !irq_q)
    else $error("enables or interrupt not cleared by reset");

  a_id_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == OFFSET_IDENTIFIER |=> rd_data_q == DEVICE_ID)
    else $error("identifier read returned wrong value");

  a_id_nowrite: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_req.wr && bus_req.addr == OFFSET_IDENTIFIER
    |=> en_first_q == $past(en_first_q) && en_second_q == $past(en_second_q))
    else $error("identifier write disturbed other registers");

  // Quiet pin when nothing enabled is set; a stuck pin would starve the host of edges
  a_masked_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(|(status_first & en_first_q)) && !(|(status_second & en_second_q)) |=> !irq_q)
    else $error("interrupt raised with no enabled flag set");

  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (en_first_q & ~WMASK_ENABLE_FIRST) == 8'h00)
    else $error("reserved enable bit holds a one");

  a_first_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_first |=> en_first_q == ($past(bus_req.wdata) & WMASK_ENABLE_FIRST))
    else $error("first enable write did not land");

  a_second_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_second |=> en_second_q == $past(bus_req.wdata))
    else $error("second enable write did not land");

  // Pending views let software find the cause without a status read elsewhere
  a_pend_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == OFFSET_PENDING_FIRST
    |=> rd_data_q == $past(status_first & en_first_q))
    else $error("first pending read returned wrong value");

  a_rd_idle_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    !bus_req.rd |=> rd_data_q == READ_UNMAPPED)
    else $error("read data not zero outside a read");

  c_irq_rise: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq_q));
  c_id_read: cover property (@(posedge core_clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == OFFSET_IDENTIFIER);
  c_pend_read: cover property (@(posedge core_clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == OFFSET_PENDING_SECOND);
  c_irq_fall: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(irq_q));
  c_wr_then_rd: cover property (@(posedge core_clk) disable iff (!rst_n)
    wr_second ##1 bus_req.rd && bus_req.addr == OFFSET_ENABLE_SECOND);

endmodule

// file: sim/host_monitor.sv
// Host-side model that counts interrupt requests seen on the pin
`timescale 1ns/100ps
module host_monitor (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic irq_q,
  output int        rises
);
  logic irq_seen_q;

  // Level pin: each low-to-high change is one service request
  always @(posedge core_clk) begin
    irq_seen_q <= rst_n & irq_q;
    if (!rst_n) rises <= 0;
    else if (irq_q && !irq_seen_q) rises <= rises + 1;
  end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the interrupt enable masking block
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp); end end
module testbench;
  import irq_enable_pkg::*;
  localparam logic [7:0] ID = 8'h3c;  // Arbitrary identifier for this run
  logic       core_clk;
  logic       rst_n;
  reg_req_t   bus_req;
  logic [7:0] st1;
  logic [7:0] st2;
  logic [7:0] rd_data_q;
  logic       irq_q;
  logic [7:0] en1_m;
  logic [7:0] en2_m;
  logic [7:0] d1;
  logic [7:0] d2;
  logic [15:0] st_r;
  logic [7:0] exp_rd;
  logic       exp_irq;
  logic       rd_d1;
  logic [7:0] exp_q[$];
  int         n_errors;
  int         check_count;
  int         rises;
  int         base;

  irq_enable_mask #(.DEVICE_ID(ID)) irq_enable_mask_inst (
    .core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .status_first(st1),
    .status_second(st2), .rd_data_q(rd_data_q), .irq_q(irq_q));
  host_monitor host_monitor_inst (.core_clk(core_clk), .rst_n(rst_n), .irq_q(irq_q),
    .rises(rises));

  // Reference: enables as written, interrupt one cycle behind its inputs
  always @(posedge core_clk) begin
    rd_d1 <= rst_n & bus_req.rd;
    exp_irq <= rst_n & ((|(st1 & en1_m)) | (|(st2 & en2_m)));
    if (!rst_n) {en2_m, en1_m} <= 16'h0000;
    else if (bus_req.wr && bus_req.addr == OFFSET_ENABLE_FIRST)
      en1_m <= bus_req.wdata & WMASK_ENABLE_FIRST;
    else if (bus_req.wr && bus_req.addr == OFFSET_ENABLE_SECOND) en2_m <= bus_req.wdata;
  end

  always @(posedge core_clk) begin
    if (rd_d1) begin
      exp_rd = exp_q.pop_front();
      `CHK(rd_data_q, exp_rd, "read data")
    end
  end

  always @(negedge core_clk) if (rst_n) `CHK(irq_q, exp_irq, "interrupt")

  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 8'h00, 1'b0, 1'b1);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    #200us;
    n_errors++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    {st2, st1} = 16'h0000;
    void'($urandom(32'h3c9788e3));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(OFFSET_ENABLE_FIRST, RESET_ENABLE_FIRST);
    rd(OFFSET_ENABLE_SECOND, RESET_ENABLE_SECOND);
    bus(OFFSET_IDENTIFIER, 8'ha5, 1'b1, 1'b0);
    rd(OFFSET_IDENTIFIER, ID);
    bus(8'h40, 8'hff, 1'b1, 1'b0);
    rd(8'h40, READ_UNMAPPED);
    $display("test reset_and_identifier done");
    // One enable bit at a time; flags of the other register are all set as decoys
    base = rises;
    for (int r = 0; r < 2; r++) begin
      for (int b = 0; b < 8; b++) begin
        {st2, st1} <= 16'h0000;
        bus(OFFSET_ENABLE_FIRST, r ? 8'h00 : 8'h01 << b, 1'b1, 1'b0);
        bus(OFFSET_ENABLE_SECOND, r ? 8'h01 << b : 8'h00, 1'b1, 1'b0);
        {st2, st1} <= r ? {8'h01 << b, 8'hff} : {8'hff, 8'h01 << b};
        repeat (2) bus(8'h00, 8'h00, 1'b0, 1'b0);
        {st2, st1} <= ~{st2, st1};
        repeat (2) bus(8'h00, 8'h00, 1'b0, 1'b0);
      end
    end
    `CHK(rises - base, 14, "interrupt rises")
    $display("test single_bit_gating done");
    for (int i = 0; i < 24; i++) begin
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      bus(OFFSET_ENABLE_FIRST, d1, 1'b1, 1'b0);
      bus(OFFSET_ENABLE_SECOND, d2, 1'b1, 1'b0);
      st_r = 16'($urandom);
      {st2, st1} <= st_r;
      rd(OFFSET_ENABLE_FIRST, d1 & WMASK_ENABLE_FIRST);
      rd(OFFSET_ENABLE_SECOND, d2);
      rd(OFFSET_PENDING_FIRST, st_r[7:0] & d1 & WMASK_ENABLE_FIRST);
      rd(OFFSET_PENDING_SECOND, st_r[15:8] & d2);
    end
    repeat (3) bus(8'h00, 8'h00, 1'b0, 1'b0);
    $display("test random_masking done");
    end_sim();
  end
endmodule
